// File: rtl/srp_rx_port.sv
/*
 * srp_rx_port: receive data path and processor bus port of a synchronous
 * serial adapter, with a minimal fill-character transmitter.
 * Assumes every pin is asynchronous to clk_sys and the bus enable and
 * line clocks run well below a quarter of clk_sys.
 */
// Functional notes
// - synchronized characters shift toward last empty slot
// - single-byte mode: avail when slot three full
// - two-byte mode: avail when last two full
// - avail with receive enable raises interrupt
// - fifo read clears avail and interrupt
// - queued characters shift in, flags set again
// - parity kept per character, never on bus
// - parity fault interrupts when error enable set
// - entry into full input slot overflows, overwrites
// - overflow interrupts when error enable set
// - overflow clears after status then read, or on rx hold
// - carrier input rising interrupts with error enable, not during rx hold
// - carrier clear after status then read, track
// - bus driven only during selected read
// - read selects read register, write the other
// - selected only while chip select low
// - bank select picks register pair
// - interrupt open drain, held until cleared
// - reset pin sets holds, clears controls
// - holds stay; reset bits ignore writes meanwhile
// - tx shifts on falling, rx samples rising
// - bus enable clocks transfers and fifo
// - control 1 written at bank low, write
// - periph_ctl_low clear gives inverse of high
`timescale 1ns/1ps
module srp_rx_port (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic bus_enable,
	input wire logic chip_sel_n,
	input wire logic reg_bank_select,
	input wire logic read_write,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe,
	output logic irq_n_o,
	output logic irq_n_oe,
	input wire logic reset_pin_n,
	input wire logic rx_clk,
	input wire logic rx_data,
	input wire logic carrier_n,
	input wire logic tx_clk,
	output logic tx_data_out,
	output logic match_or_ready_out
);
	import srp_pkg::*;

	srp_st_t q;
	srp_st_t d;
	srp_pin_t pins;
	logic e_fall;
	logic sel;
	logic rd_stat;
	logic rd_fifo;
	logic wr_c1;
	logic wr_hi;
	logic ext_rst;
	logic rx_rise;
	logic tx_fall;
	logic car_rise;
	logic rx_done;
	logic [7:0] rx_word;
	logic rx_perr;
	logic mv12;
	logic mv01;
	logic rx_avail;
	logic tx_space;
	logic [7:0] status;

	function automatic logic parity_bad(input logic [7:0] w, input logic p,
		input logic odd);
		parity_bad = ((^w) ^ p) != odd;
	endfunction : parity_bad

	assign pins = '{e: bus_enable, cs_n: chip_sel_n, rs: reg_bank_select,
		rw: read_write, din: data_i, rxc: rx_clk, rxd: rx_data,
		car_n: carrier_n, txc: tx_clk, rst_n: reset_pin_n};

	// ************************************************************
	// bus decode
	// ************************************************************
	assign e_fall = q.e_p & ~q.s2.e;
	assign sel = e_fall & ~q.s2.cs_n;
	assign rd_stat = sel & ~q.s2.rs & q.s2.rw;
	assign wr_c1 = sel & ~q.s2.rs & ~q.s2.rw;
	assign rd_fifo = sel & q.s2.rs & q.s2.rw;
	assign wr_hi = sel & q.s2.rs & ~q.s2.rw;
	assign ext_rst = ~q.s2.rst_n;
	assign rx_rise = ~q.rxc_p & q.s2.rxc;
	assign tx_fall = q.txc_p & ~q.s2.txc;
	assign car_rise = ~q.car_p & q.s2.car_n;

	// ************************************************************
	// receive shifter
	// ************************************************************
	always_comb begin
		rx_word = {q.s2.rxd, q.rx_sh[7:1]};
		rx_done = 1'b0;
		rx_perr = 1'b0;
		if (rx_rise && !q.rx_hold && !q.s2.car_n) begin
			if (q.rx_cnt == RX_PAR) begin
				rx_word = q.rx_sh;
				rx_done = 1'b1;
				rx_perr = parity_bad(q.rx_sh, q.s2.rxd, q.par_odd);
			end else if (q.rx_cnt == RX_LAST && !q.par_en) begin
				rx_done = 1'b1;
			end
		end
	end

	assign mv12 = e_fall & q.fv[1] & ~q.fv[2];
	assign mv01 = e_fall & q.fv[0] & (~q.fv[1] | mv12);
	assign rx_avail = q.two_byte ? (q.fv[2] & q.fv[1]) : q.fv[2];
	assign tx_space = ~q.tx_full & ~q.tx_hold & ~ext_rst;
	always_comb begin
		status = 8'h00;
		status[ST_AVAIL] = rx_avail;
		status[ST_TX_SPACE] = tx_space;
		status[ST_CARRIER] = q.dcd_lat | q.s2.car_n;
		status[ST_OVERFLOW] = q.ovr;
		status[ST_PARITY] = q.fv[2] & q.fp[2];
		status[ST_IRQ] = q.irq;
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.e_p = q.s2.e;
		d.rxc_p = q.s2.rxc;
		d.txc_p = q.s2.txc;
		d.car_p = q.s2.car_n;
		if (wr_c1) begin
			d.rx_ie = q.s2.din[C1_RX_IE];
			d.ac = q.s2.din[C1_AC_LO +: 2];
			if (!ext_rst) begin
				d.rx_hold = q.s2.din[C1_RX_HOLD];
				d.tx_hold = q.s2.din[C1_TX_HOLD];
			end
		end
		if (wr_hi) begin
			case (q.ac)
				AC_CTL2: begin
					d.two_byte = q.s2.din[C2_TWO_BYTE];
					if (!ext_rst) begin
						d.pc_low = q.s2.din[C2_PC_LOW];
						d.pc_high = q.s2.din[C2_PC_HIGH];
						d.err_irq_en = q.s2.din[C2_ERR_IE];
					end
				end
				AC_CTL3: begin
					d.par_en = q.s2.din[C3_PAR_EN];
					d.par_odd = q.s2.din[C3_PAR_ODD];
					if (!ext_rst) begin
						d.sync_ext = q.s2.din[C3_SYNC_EXT];
					end
				end
				AC_SYNC: d.sync_code = q.s2.din;
				AC_TXD: begin
					d.tx_buf = q.s2.din;
					d.tx_full = 1'b1;
				end
				default: d.sync_code = q.sync_code;
			endcase
		end
		if (ext_rst) begin
			d.rx_hold = 1'b1;
			d.tx_hold = 1'b1;
			d.pc_low = 1'b0;
			d.pc_high = 1'b0;
			d.err_irq_en = 1'b0;
			d.sync_ext = 1'b0;
		end
		// transmitter: fill with sync code when nothing is queued
		if (q.tx_hold) begin
			d.tx_full = 1'b0;
			d.tx_cnt = 3'h0;
			d.tx_line = 1'b1;
		end else if (tx_fall) begin
			if (q.tx_cnt == 3'h0) begin
				d.tx_sh = q.tx_full ? q.tx_buf : q.sync_code;
				d.tx_full = 1'b0;
				d.tx_cnt = TX_LAST;
				d.tx_line = d.tx_sh[0];
				d.tx_sh = {1'b1, d.tx_sh[7:1]};
			end else begin
				d.tx_line = q.tx_sh[0];
				d.tx_sh = {1'b1, q.tx_sh[7:1]};
				d.tx_cnt = q.tx_cnt - 3'h1;
			end
		end
		// receive fifo
		if (mv12) begin
			d.fd[2] = q.fd[1];
			d.fp[2] = q.fp[1];
			d.fv[2] = 1'b1;
			d.fv[1] = 1'b0;
		end
		if (mv01) begin
			d.fd[1] = q.fd[0];
			d.fp[1] = q.fp[0];
			d.fv[1] = 1'b1;
			d.fv[0] = 1'b0;
		end
		if (rd_fifo && q.fv[2]) begin
			d.fv[2] = 1'b0;
			d.fp[2] = 1'b0;
		end
		if (rd_stat && q.ovr) begin
			d.ovr_seen = 1'b1;
		end
		if (rd_stat && q.dcd_lat) begin
			d.dcd_seen = 1'b1;
		end
		if (rd_fifo && q.ovr_seen) begin
			d.ovr = 1'b0;
			d.ovr_seen = 1'b0;
		end
		if (rd_fifo && q.dcd_seen) begin
			d.dcd_lat = 1'b0;
			d.dcd_seen = 1'b0;
		end
		if (car_rise) begin
			d.dcd_lat = 1'b1;
		end
		if (rx_rise && !q.rx_hold && !q.s2.car_n) begin
			if (q.rx_cnt != RX_PAR) begin
				d.rx_sh = rx_word;
			end
			d.rx_cnt = rx_done ? 4'h0 : q.rx_cnt + 4'h1;
		end
		if (q.s2.car_n) begin
			d.rx_cnt = 4'h0;
		end
		if (rx_done) begin
			if (q.fv[0] && !mv01) begin
				d.ovr = 1'b1;
				d.ovr_seen = 1'b0;
			end
			d.fd[0] = rx_word;
			d.fp[0] = rx_perr & q.par_en;
			d.fv[0] = 1'b1;
		end
		if (q.rx_hold) begin
			d.fv = 3'h0;
			d.fp = 3'h0;
			d.ovr = 1'b0;
			d.ovr_seen = 1'b0;
			d.dcd_lat = 1'b0;
			d.dcd_seen = 1'b0;
			d.rx_sh = 8'hff;
			d.rx_cnt = 4'h0;
		end
		d.irq = (q.rx_ie & rx_avail)
			| (q.err_irq_en & (status[ST_PARITY] | q.ovr | q.dcd_lat));
		d.dout = q.s2.rs ? q.fd[2] : status;
		d.mr_out = q.pc_low ? 1'b0 : ~q.pc_high;
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.s1 <= '1;
			q.s2 <= '1;
			q.e_p <= 1'b1;
			q.car_p <= 1'b1;
			q.rxc_p <= 1'b1;
			q.txc_p <= 1'b1;
			q.rx_hold <= 1'b1;
			q.tx_hold <= 1'b1;
			q.tx_line <= 1'b1;
			q.rx_sh <= 8'hff;
			q.mr_out <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign data_o = q.dout;
	assign data_oe = q.s2.e & ~q.s2.cs_n & q.s2.rw;
	assign irq_n_o = 1'b0;
	assign irq_n_oe = q.irq;
	assign tx_data_out = q.tx_line;
	assign match_or_ready_out = q.mr_out;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence car_latched;
		car_rise && q.err_irq_en && !q.rx_hold ##1 q.dcd_lat && q.err_irq_en;
	endsequence

	fifo_advance_a: assert property (
		mv12 && !q.rx_hold |=> q.fv[2] && q.fd[2] == $past(q.fd[1]))
		else $error("fifo did not advance into last slot");
	avail_two_a: assert property (
		q.two_byte && q.fv[2] && !q.fv[1] |-> !rx_avail ##1 !q.irq || q.err_irq_en)
		else $error("avail set with one byte in two-byte mode");
	read_clear_a: assert property (
		rd_fifo && q.fv[2] && !q.rx_hold |=> !q.fv[2] ##1
		!q.irq || q.err_irq_en || rx_avail)
		else $error("fifo read left data flagged");
	rx_irq_a: assert property (
		q.rx_ie && rx_avail |=> irq_n_oe && !irq_n_o)
		else $error("receive interrupt missing");
	parity_keep_a: assert property (
		q.fv[2] && !rd_fifo && !q.rx_hold |=> $stable(q.fp[2]) && q.fv[2])
		else $error("parity result lost before read");
	overrun_set_a: assert property (
		rx_done && q.fv[0] && !mv01 && !q.rx_hold |=> q.ovr ##1
		q.irq || !q.err_irq_en)
		else $error("overrun not flagged");
	overrun_hold_a: assert property (
		$fell(q.ovr) |-> $past(q.ovr_seen) || $past(q.rx_hold))
		else $error("overrun cleared without status read");
	carrier_irq_a: assert property (
		car_latched |=> q.irq)
		else $error("carrier interrupt missing");
	reset_hold_a: assert property (
		ext_rst |=> q.rx_hold && q.tx_hold && !q.err_irq_en && !q.pc_low)
		else $error("reset pin did not force controls");
	write_gate_a: assert property (
		ext_rst && wr_c1 |=> q.rx_hold && q.tx_hold)
		else $error("hold bits written during reset");
	ready_level_a: assert property (
		!q.pc_low |=> match_or_ready_out == !$past(q.pc_high))
		else $error("ready level wrong");
	bus_drive_a: assert property (
		data_oe |-> $past(bus_enable, 2) && !$past(chip_sel_n, 2) &&
		$past(read_write, 2))
		else $error("bus driven outside selected read");

endmodule : srp_rx_port

// File: rtl/srp_pkg.sv
/*
 * srp_pkg: shared constants and state types for the synchronous serial
 * receive port. Assumes an 8-bit processor bus sampled by clk_sys.
 */
package srp_pkg;

	// ************************************************************
	// bus decode and register fields
	// ************************************************************
	localparam int WORD_BITS = 8;
	localparam int FIFO_DEPTH = 3;
	localparam logic [1:0] AC_CTL2 = 2'h0;
	localparam logic [1:0] AC_CTL3 = 2'h1;
	localparam logic [1:0] AC_SYNC = 2'h2;
	localparam logic [1:0] AC_TXD = 2'h3;
	// control 1
	localparam int C1_RX_HOLD = 0;
	localparam int C1_TX_HOLD = 1;
	localparam int C1_RX_IE = 5;
	localparam int C1_AC_LO = 6;
	// control 2
	localparam int C2_PC_LOW = 0;
	localparam int C2_PC_HIGH = 1;
	localparam int C2_TWO_BYTE = 2;
	localparam int C2_ERR_IE = 5;
	// control 3
	localparam int C3_SYNC_EXT = 0;
	localparam int C3_PAR_EN = 1;
	localparam int C3_PAR_ODD = 2;
	// status
	localparam int ST_AVAIL = 0;
	localparam int ST_TX_SPACE = 1;
	localparam int ST_CARRIER = 2;
	localparam int ST_OVERFLOW = 5;
	localparam int ST_PARITY = 6;
	localparam int ST_IRQ = 7;
	localparam logic [3:0] RX_LAST = 4'h7;
	localparam logic [3:0] RX_PAR = 4'h8;
	localparam logic [2:0] TX_LAST = 3'h7;

	// ************************************************************
	// state types
	// ************************************************************
	typedef struct packed {
		logic e;
		logic cs_n;
		logic rs;
		logic rw;
		logic [7:0] din;
		logic rxc;
		logic rxd;
		logic car_n;
		logic txc;
		logic rst_n;
	} srp_pin_t;

	typedef struct packed {
		srp_pin_t s1;
		srp_pin_t s2;
		logic e_p;
		logic rxc_p;
		logic txc_p;
		logic car_p;
		logic rx_hold;
		logic tx_hold;
		logic rx_ie;
		logic [1:0] ac;
		logic pc_low;
		logic pc_high;
		logic two_byte;
		logic err_irq_en;
		logic sync_ext;
		logic par_en;
		logic par_odd;
		logic [7:0] sync_code;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		logic tx_line;
		logic [7:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [2:0][7:0] fd;
		logic [2:0] fv;
		logic [2:0] fp;
		logic ovr;
		logic ovr_seen;
		logic dcd_lat;
		logic dcd_seen;
		logic irq;
		logic [7:0] dout;
		logic mr_out;
	} srp_st_t;

endpackage : srp_pkg

// File: bench/srp_line_src.sv
/*
 * srp_line_src: serial line source feeding the receive port, LSB first.
 * Assumes the receiver samples rx_data on the rising edge of rx_clk.
 */
`timescale 1ns/1ps
module srp_line_src (
	output logic rx_clk,
	output logic rx_data
);
	initial begin
		rx_clk = 1'b0;
		rx_data = 1'b1;
	end

	// ************************************************************
	// frame sender: clock stands low between frames
	// ************************************************************
	task automatic send(input logic [8:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rx_data = bits[i];
			#160 rx_clk = 1'b1;
			#160 rx_clk = 1'b0;
		end
		// released line must not keep showing the last bit
		rx_data = ~rx_data;
		#160;
	endtask : send
endmodule : srp_line_src

// File: bench/srp_rx_port_tb.sv
/*
 * srp_rx_port_tb: self-checking bench for the receive port.
 * Assumes srp_line_src drives the serial line and E runs 5 clk per phase.
 */
`timescale 1ns/1ps
module srp_rx_port_tb;
	logic clk_sys = 1'b0, nrst = 1'b0, bus_enable = 1'b0;
	logic chip_sel_n = 1'b1, reg_bank_select = 1'b0, read_write = 1'b1;
	logic [7:0] data_i = 8'h00;
	logic reset_pin_n = 1'b0, carrier_n = 1'b0, tx_clk = 1'b0;
	logic [7:0] data_o;
	logic data_oe, irq_n_o, irq_n_oe, tx_data_out, match_or_ready_out;
	logic rx_clk, rx_data;
	int miscompares = 0;
	int checked = 0;

	always #20 clk_sys = ~clk_sys;

	srp_line_src u_src (.rx_clk(rx_clk), .rx_data(rx_data));
	srp_rx_port DUT (.clk_sys(clk_sys), .nrst(nrst), .bus_enable(bus_enable),
		.chip_sel_n(chip_sel_n), .reg_bank_select(reg_bank_select),
		.read_write(read_write), .data_i(data_i), .data_o(data_o),
		.data_oe(data_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
		.reset_pin_n(reset_pin_n), .rx_clk(rx_clk), .rx_data(rx_data),
		.carrier_n(carrier_n), .tx_clk(tx_clk), .tx_data_out(tx_data_out),
		.match_or_ready_out(match_or_ready_out));

	// ************************************************************
	// compare and bus tasks
	// ************************************************************
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit

	task automatic ecyc(input logic cs, input logic rs, input logic rw,
			input logic [7:0] wd, output logic [7:0] rd);
		@(negedge clk_sys);
		chip_sel_n = cs;
		reg_bank_select = rs;
		read_write = rw;
		data_i = wd;
		bus_enable = 1'b1;
		repeat (5) @(negedge clk_sys);
		chk_bit(data_oe, !cs && rw);
		rd = data_o;
		bus_enable = 1'b0;
		repeat (5) @(negedge clk_sys);
		chip_sel_n = 1'b1;
	endtask : ecyc

	task automatic idle(input int n);
		logic [7:0] rd;
		repeat (n) ecyc(1'b1, 1'b0, 1'b1, 8'h00, rd);
	endtask : idle

	task automatic wr(input logic rs, input logic [7:0] d);
		logic [7:0] rd;
		ecyc(1'b0, rs, 1'b0, d, rd);
	endtask : wr

	task automatic rd_chk(input logic rs, input logic [7:0] exp,
			input logic [7:0] mask);
		logic [7:0] rd;
		ecyc(1'b0, rs, 1'b1, 8'h00, rd);
		chk_byte(rd & mask, exp & mask);
	endtask : rd_chk

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		chk_bit(match_or_ready_out, 1'b1);
		chk_bit(tx_data_out, 1'b1);
		chk_bit(irq_n_oe, 1'b0);
		wr(1'b1, 8'h22);
		reset_pin_n = 1'b1;
		idle(1);
		chk_bit(match_or_ready_out, 1'b1);
		rd_chk(1'b0, 8'h00, 8'h02);
		u_src.send(9'h0a5, 8);
		idle(3);
		rd_chk(1'b0, 8'h00, 8'h01);
		wr(1'b0, 8'h20);
		wr(1'b1, 8'h22);
		chk_bit(match_or_ready_out, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_tx;
		logic [15:0] exp_bits;
		exp_bits = 16'h3c96;
		wr(1'b0, 8'ha0);
		wr(1'b1, 8'h3c);
		wr(1'b0, 8'he0);
		wr(1'b1, 8'h96);
		// data byte first, then the sync code as fill
		for (int i = 0; i < 16; i++) begin
			tx_clk = 1'b1;
			repeat (4) @(negedge clk_sys);
			tx_clk = 1'b0;
			repeat (4) @(negedge clk_sys);
			chk_bit(tx_data_out, exp_bits[i]);
		end
		wr(1'b0, 8'h20);
		$display("test transmit done");
	endtask : t_tx

	task automatic t_pin_reset;
		reset_pin_n = 1'b0;
		idle(1);
		chk_bit(match_or_ready_out, 1'b1);
		rd_chk(1'b0, 8'h00, 8'h02);
		wr(1'b0, 8'h20);
		reset_pin_n = 1'b1;
		idle(1);
		chk_bit(match_or_ready_out, 1'b1);
		u_src.send(9'h0a5, 8);
		idle(3);
		rd_chk(1'b0, 8'h00, 8'h81);
		$display("test pin reset done");
	endtask : t_pin_reset

	task automatic t_single;
		u_src.send(9'h0a5, 8);
		idle(3);
		rd_chk(1'b0, 8'h81, 8'hfd);
		chk_bit(irq_n_oe, 1'b1);
		chk_bit(irq_n_o, 1'b0);
		rd_chk(1'b1, 8'ha5, 8'hff);
		idle(1);
		rd_chk(1'b0, 8'h00, 8'hfd);
		chk_bit(irq_n_oe, 1'b0);
		u_src.send(9'h03c, 8);
		idle(1);
		u_src.send(9'h0c3, 8);
		idle(3);
		rd_chk(1'b1, 8'h3c, 8'hff);
		idle(1);
		rd_chk(1'b0, 8'h81, 8'hfd);
		rd_chk(1'b1, 8'hc3, 8'hff);
		$display("test single done");
	endtask : t_single

	task automatic t_two_byte;
		wr(1'b1, 8'h26);
		u_src.send(9'h011, 8);
		idle(1);
		rd_chk(1'b0, 8'h00, 8'h01);
		u_src.send(9'h022, 8);
		idle(2);
		rd_chk(1'b0, 8'h81, 8'hfd);
		rd_chk(1'b1, 8'h11, 8'hff);
		idle(1);
		rd_chk(1'b1, 8'h22, 8'hff);
		wr(1'b1, 8'h22);
		$display("test two byte done");
	endtask : t_two_byte

	task automatic t_parity;
		wr(1'b0, 8'h60);
		wr(1'b1, 8'h02);
		u_src.send(9'h003, 9);
		idle(1);
		u_src.send(9'h001, 9);
		idle(3);
		rd_chk(1'b0, 8'h81, 8'hfd);
		rd_chk(1'b1, 8'h03, 8'hff);
		idle(1);
		rd_chk(1'b0, 8'hc1, 8'hfd);
		rd_chk(1'b1, 8'h01, 8'hff);
		wr(1'b1, 8'h00);
		wr(1'b0, 8'h20);
		$display("test parity done");
	endtask : t_parity

	task automatic t_overflow;
		u_src.send(9'h0aa, 8);
		u_src.send(9'h055, 8);
		idle(3);
		rd_chk(1'b1, 8'h55, 8'hff);
		rd_chk(1'b0, 8'ha0, 8'hfd);
		rd_chk(1'b1, 8'h00, 8'h00);
		idle(1);
		rd_chk(1'b0, 8'h00, 8'hfd);
		$display("test overflow done");
	endtask : t_overflow

	task automatic t_carrier;
		carrier_n = 1'b1;
		idle(1);
		rd_chk(1'b0, 8'h84, 8'hfd);
		chk_bit(irq_n_oe, 1'b1);
		carrier_n = 1'b0;
		idle(1);
		rd_chk(1'b0, 8'h84, 8'hfd);
		rd_chk(1'b1, 8'h00, 8'h00);
		idle(1);
		rd_chk(1'b0, 8'h00, 8'hfd);
		chk_bit(irq_n_oe, 1'b0);
		$display("test carrier done");
	endtask : t_carrier

	// ************************************************************
	// run control
	// ************************************************************
	task automatic results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	initial begin
		#2000000;
		miscompares++;
		results();
	end

	initial begin
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (3) @(negedge clk_sys);
		t_reset();
		t_tx();
		t_single();
		t_two_byte();
		t_parity();
		t_overflow();
		t_carrier();
		t_pin_reset();
		results();
	end
endmodule : srp_rx_port_tb
